// File: core/psr_pkg.sv
package psr_pkg;
  localparam logic [8:0] PSR_OFFSET       = 9'h003;
  localparam logic [6:0] PSR_MIRROR_MASK  = 7'h7F;
  localparam int         POS_INDIRECT     = 7;
  localparam int         POS_BANK_HIGH    = 6;
  localparam int         POS_BANK_LOW     = 5;
  localparam int         POS_WDOG         = 4;
  localparam int         POS_PSAVE        = 3;
  localparam int         POS_ZERO         = 2;
  localparam int         POS_NIBBLE       = 1;
  localparam int         POS_CARRY        = 0;
  localparam logic [2:0] RST_BANK         = 3'h0;
  localparam logic       RST_WDOG         = 1'b1;
  localparam logic       RST_PSAVE        = 1'b1;
  localparam logic [2:0] RST_ALU_FLAGS    = 3'h0;
  localparam logic [7:0] RST_RESULT       = 8'h00;

  typedef enum logic [2:0] {
    PSR_OP_NONE  = 3'h0,
    PSR_OP_ADD   = 3'h1,
    PSR_OP_SUB   = 3'h3,
    PSR_OP_LOGIC = 3'h2,
    PSR_OP_CLEAR = 3'h6
  } psr_op_e;

  typedef struct packed {
    logic       wr_en;
    logic [8:0] addr;
    logic [7:0] wdata;
  } psr_wr_s;

  typedef struct packed {
    logic [1:0] direct_bank;
    logic       indirect_bank_bit;
  } psr_bank_s;
endpackage : psr_pkg

// File: core/psr_status_bank.sv
`timescale 1ns/10ps
module psr_status_bank (
  input  wire logic             i_sys_clk,
  input  wire logic             i_arst_n,
  input  wire psr_pkg::psr_wr_s i_wr,
  input  wire psr_pkg::psr_op_e i_alu_op,
  input  wire logic [7:0]       i_alu_a,
  input  wire logic [7:0]       i_alu_b,
  input  wire logic [7:0]       i_logic_result,
  input  wire logic             i_watchdog_clear_instr,
  input  wire logic             i_sleep_instr,
  input  wire logic             i_watchdog_timeout,
  input  wire logic             i_prescaler_route_bit,
  input  wire logic             i_timer_tick,
  input  wire logic             i_prescaled_tick,
  output logic [7:0]            o_status,
  output logic [7:0]            o_alu_result,
  output psr_pkg::psr_bank_s    o_bank,
  output logic                  o_timer_zero_tick
);
  logic       indirect_bank_bit;
  logic       direct_bank_high;
  logic       direct_bank_low;
  logic       watchdog_expiry_flag;
  logic       power_save_flag;
  logic       zero_flag;
  logic       nibble_out_flag;
  logic       carry_flag;
  logic       hit;
  logic       flag_op;
  logic [7:0] operand_b;
  logic       carry_in;
  logic [4:0] low_sum;
  logic [8:0] full_sum;
  logic [7:0] next_result;
  logic       next_zero;
  logic       next_nibble;
  logic       next_carry;

  // status mirrored in every bank
  assign hit = i_wr.wr_en &&
               (i_wr.addr[6:0] == psr_pkg::PSR_OFFSET[6:0]);
  assign flag_op = (i_alu_op != psr_pkg::PSR_OP_NONE);

  // subtract as a + ~b + 1
  always_comb begin
    operand_b = i_alu_b;
    carry_in  = 1'b0;
    if (i_alu_op == psr_pkg::PSR_OP_SUB) begin
      operand_b = ~i_alu_b;
      carry_in  = 1'b1;
    end
  end

  assign low_sum  = {1'b0, i_alu_a[3:0]} + {1'b0, operand_b[3:0]}
                    + {4'h0, carry_in};
  assign full_sum = {1'b0, i_alu_a} + {1'b0, operand_b} + {8'h00, carry_in};

  always_comb begin
    next_result = 8'h00;
    next_zero   = zero_flag;
    next_nibble = nibble_out_flag;
    next_carry  = carry_flag;
    case (i_alu_op)
      psr_pkg::PSR_OP_ADD,
      psr_pkg::PSR_OP_SUB: begin
        next_result = full_sum[7:0];
        next_carry  = full_sum[8];
        next_nibble = low_sum[4];
        next_zero   = (full_sum[7:0] == 8'h00);
      end
      psr_pkg::PSR_OP_LOGIC: begin
        next_result = i_logic_result;
        next_zero   = (i_logic_result == 8'h00);
      end
      psr_pkg::PSR_OP_CLEAR: begin
        next_result = 8'h00;
        next_zero   = 1'b1;
      end
      psr_pkg::PSR_OP_NONE: begin
        next_result = i_wr.wdata;
      end
      default: begin
        next_result = 8'h00;
      end
    endcase
  end

  // result of the last instruction, one cycle after it
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_alu_result <= psr_pkg::RST_RESULT;
    end else begin
      o_alu_result <= next_result;
    end
  end

  // bank select bits: plain write of the result value
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      {indirect_bank_bit, direct_bank_high, direct_bank_low} <=
        psr_pkg::RST_BANK;
    end else if (hit) begin
      indirect_bank_bit <= next_result[psr_pkg::POS_INDIRECT];
      direct_bank_high  <= next_result[psr_pkg::POS_BANK_HIGH];
      direct_bank_low   <= next_result[psr_pkg::POS_BANK_LOW];
    end
  end

  // alu flags: result wins over destination write
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      {zero_flag, nibble_out_flag, carry_flag} <= psr_pkg::RST_ALU_FLAGS;
    end else if (flag_op) begin
      zero_flag       <= next_zero;
      nibble_out_flag <= next_nibble;
      carry_flag      <= next_carry;
    end else if (hit) begin
      zero_flag       <= i_wr.wdata[psr_pkg::POS_ZERO];
      nibble_out_flag <= i_wr.wdata[psr_pkg::POS_NIBBLE];
      carry_flag      <= i_wr.wdata[psr_pkg::POS_CARRY];
    end
  end

  // reset-cause bits: hardware only, timeout wins on expiry flag, sleep wins on power-save flag
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      watchdog_expiry_flag <= psr_pkg::RST_WDOG;
      power_save_flag      <= psr_pkg::RST_PSAVE;
    end else begin
      if (i_watchdog_timeout) begin
        watchdog_expiry_flag <= 1'b0;
      end else if (i_watchdog_clear_instr || i_sleep_instr) begin
        watchdog_expiry_flag <= 1'b1;
      end
      if (i_sleep_instr) begin
        power_save_flag <= 1'b0;
      end else if (i_watchdog_clear_instr) begin
        power_save_flag <= 1'b1;
      end
    end
  end

  assign o_status = {indirect_bank_bit, direct_bank_high, direct_bank_low,
                     watchdog_expiry_flag, power_save_flag, zero_flag,
                     nibble_out_flag, carry_flag};
  assign o_bank.indirect_bank_bit = indirect_bank_bit;
  assign o_bank.direct_bank = {direct_bank_high, direct_bank_low};
  // timer tick bypasses prescaler when routed to watchdog
  assign o_timer_zero_tick =
    i_prescaler_route_bit ? i_timer_tick : i_prescaled_tick;

  AST_SW_NO_WDOG: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (!i_watchdog_timeout && !i_watchdog_clear_instr && !i_sleep_instr)
    |=> $stable(watchdog_expiry_flag) && $stable(power_save_flag))
    else $error("reset-cause bit changed without event");
  AST_FLAG_PRIORITY: assert property (@(posedge i_sys_clk)
    disable iff (!i_arst_n)
    (hit && i_alu_op == psr_pkg::PSR_OP_ADD)
    |=> carry_flag == $past(full_sum[8]))
    else $error("destination write overrode carry");
  AST_CLEAR: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (hit && i_alu_op == psr_pkg::PSR_OP_CLEAR && !i_watchdog_timeout
     && !i_watchdog_clear_instr && !i_sleep_instr)
    |=> o_status[7:5] == 3'h0 && zero_flag
        && $stable(o_status[4:3]) && $stable(o_status[1:0]))
    else $error("clear-file result wrong");
  AST_WDOG_TIMEOUT: assert property (@(posedge i_sys_clk)
    disable iff (!i_arst_n)
    i_watchdog_timeout |=> !watchdog_expiry_flag)
    else $error("timeout did not clear expiry flag");
  AST_SLEEP: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (i_sleep_instr && !i_watchdog_timeout)
    |=> !power_save_flag && watchdog_expiry_flag)
    else $error("halt did not update reset-cause bits");
  AST_SUB_CARRY: assert property (@(posedge i_sys_clk)
    disable iff (!i_arst_n)
    (i_alu_op == psr_pkg::PSR_OP_SUB)
    |=> carry_flag == ($past(i_alu_a) >= $past(i_alu_b)))
    else $error("subtract carry is not inverted borrow");
  AST_ADD_CARRY: assert property (@(posedge i_sys_clk)
    disable iff (!i_arst_n)
    (i_alu_op == psr_pkg::PSR_OP_ADD)
    |=> carry_flag == (({1'b0, $past(i_alu_a)} + {1'b0, $past(i_alu_b)})
                       > 9'h0FF))
    else $error("add carry wrong");
  AST_ZERO: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (i_alu_op == psr_pkg::PSR_OP_LOGIC)
    |=> zero_flag == ($past(i_logic_result) == 8'h00))
    else $error("zero flag wrong");
  AST_BANK_OUT: assert property (@(posedge i_sys_clk)
    disable iff (!i_arst_n)
    (hit && i_alu_op == psr_pkg::PSR_OP_NONE)
    |=> o_bank.direct_bank == $past(i_wr.wdata[6:5])
        && o_bank.indirect_bank_bit == $past(i_wr.wdata[7]))
    else $error("bank select not taken from write");
  AST_TIMER_BYPASS: assert property (@(posedge i_sys_clk)
    disable iff (!i_arst_n)
    i_prescaler_route_bit |-> o_timer_zero_tick == i_timer_tick)
    else $error("timer divided while prescaler routed away");
  AST_PLAIN_WRITE: assert property (@(posedge i_sys_clk)
    disable iff (!i_arst_n)
    (hit && i_alu_op == psr_pkg::PSR_OP_NONE)
    |=> o_status[2:0] == $past(i_wr.wdata[2:0]))
    else $error("plain write did not reach alu flags");
  AST_SUB_NIBBLE: assert property (@(posedge i_sys_clk)
    disable iff (!i_arst_n)
    (i_alu_op == psr_pkg::PSR_OP_SUB)
    |=> nibble_out_flag == ($past(i_alu_a[3:0]) >= $past(i_alu_b[3:0])))
    else $error("subtract nibble flag is not inverted borrow");
  AST_HALT_BEATS_CLEAR: assert property (@(posedge i_sys_clk)
    disable iff (!i_arst_n)
    (i_sleep_instr && i_watchdog_clear_instr)
    |=> !power_save_flag)
    else $error("halt did not win over watchdog clear");
  AST_LOGIC_KEEPS: assert property (@(posedge i_sys_clk)
    disable iff (!i_arst_n)
    (i_alu_op == psr_pkg::PSR_OP_LOGIC)
    |=> $stable(o_status[1:0]))
    else $error("logic operation changed carry flags");
endmodule : psr_status_bank

// File: verif/alu_status_bank_select_reg_tb_top.sv
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  bad_count++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module alu_status_bank_select_reg_tb_top;
  logic             i_sys_clk = 1'b0;
  logic             i_arst_n = 1'b0;
  logic             route = 1'b0;
  logic             tick = 1'b0;
  logic             pre = 1'b0;
  psr_pkg::psr_wr_s wr;
  psr_pkg::psr_op_e op;
  logic [7:0]       a, b, lres;
  logic [2:0]       evt;
  logic [31:0]      lfsr = 32'h1BB8;
  int               bad_count = 0;
  int               samples_checked = 0;
  int               st = 8'h18;
  int               exp_res = 0;

  psr_core_model core (.i_sys_clk(i_sys_clk), .o_wr(wr), .o_op(op), .o_a(a),
    .o_b(b), .o_lres(lres), .o_evt(evt));
  psr_status_bank DUT (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_wr(wr),
    .i_alu_op(op), .i_alu_a(a), .i_alu_b(b), .i_logic_result(lres),
    .i_watchdog_clear_instr(evt[0]), .i_sleep_instr(evt[1]),
    .i_watchdog_timeout(evt[2]), .i_prescaler_route_bit(route),
    .i_timer_tick(tick), .i_prescaled_tick(pre), .o_status(),
    .o_alu_result(), .o_bank(), .o_timer_zero_tick());

  initial begin
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_step

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  // drive one instruction and advance the reference status value
  task automatic run(input int o, hit, wd, x, y, lr, ev);
    int nb, ci, r, dc;
    core.exec(psr_pkg::psr_op_e'(o[2:0]), hit[0], 8'(wd), 8'(x), 8'(y),
              8'(lr), 3'(ev));
    ci = (o == 3);
    nb = ci ? (~y & 8'hFF) : y;
    r  = x + nb + ci;
    dc = ((x & 8'h0F) + (nb & 8'h0F) + ci) >> 4;
    exp_res = r & 8'hFF;
    if (o == 0) exp_res = wd & 8'hFF;
    if (o == 2) exp_res = lr & 8'hFF;
    if (o == 6) exp_res = 0;
    if (hit && o == 0) st = (wd & 8'hE7) | (st & 8'h18);
    if (hit && (o == 1 || o == 3)) st = (r & 8'hE0) | (st & 8'h1F);
    if (o == 1 || o == 3)
      st = (st & 8'hF8) | (((r & 8'hFF) == 0) << 2) | (dc << 1)
           | ((r >> 8) & 1);
    if (o == 2) st = (st & 8'hFB) | ((lr == 0) << 2);
    if (o == 6 && hit) st = (st & 8'h1B) | 8'h04;
    if (ev[0]) st = st | 8'h18;
    if (ev[1]) st = (st | 8'h10) & 8'hF7;
    if (ev[2]) st = st & 8'hEF;
  endtask : run

  initial begin
    repeat (12) @(negedge i_sys_clk);
    `CHK(DUT.o_status[4:3], 2'h3)
    i_arst_n = 1'b1;
    for (int k = 0; k < 8; k++) begin
      run(0, 1, (k << 5) | 8'h07, 0, 0, 0, 0);
      `CHK(DUT.o_status, 8'(st))
      `CHK(DUT.o_alu_result, 8'(exp_res))
      `CHK(DUT.o_status[4:3], 2'h3)
      `CHK(DUT.o_bank.indirect_bank_bit, k[2])
      `CHK(DUT.o_bank.direct_bank, k[1:0])
    end
    $display("bank select writes done");
    run(1, 1, 8'hFF, 8'h80, 8'h80, 0, 0);
    `CHK(DUT.o_status, 8'(st))
    for (int k = 0; k < 24; k++) begin
      lfsr = lfsr_step(lfsr);
      run(k[0] ? 3 : 1, 0, 0, lfsr[7:0], k[2] ? lfsr[7:0] : lfsr[15:8], 0, 0);
      `CHK(DUT.o_status[2], 1'(st >> 2))
      `CHK(DUT.o_status[1], 1'(st >> 1))
      `CHK(DUT.o_status[0], 1'(st))
      `CHK(DUT.o_alu_result, 8'(exp_res))
    end
    run(3, 0, 0, 8'h00, 8'h01, 0, 0);
    `CHK(DUT.o_status, 8'(st))
    run(2, 0, 0, 0, 0, 8'h00, 0);
    `CHK(DUT.o_status, 8'(st))
    run(2, 0, 0, 0, 0, 8'h5A, 0);
    `CHK(DUT.o_status, 8'(st))
    `CHK(DUT.o_alu_result, 8'(exp_res))
    $display("alu flag updates done");
    run(0, 1, 8'hE3, 0, 0, 0, 0);
    `CHK(DUT.o_status, 8'(st))
    run(6, 1, 0, 0, 0, 0, 0);
    `CHK(DUT.o_status, 8'(st))
    `CHK(DUT.o_alu_result, 8'(exp_res))
    for (int k = 0; k < 4; k++) begin
      run(0, 0, 0, 0, 0, 0, (k == 3) ? 1 : 4 >> (k % 3));
      `CHK(DUT.o_status[4], 1'(st >> 4))
      `CHK(DUT.o_status[3], 1'(st >> 3))
    end
    run(0, 0, 0, 0, 0, 0, 7);
    `CHK(DUT.o_status[4:3], 2'(st >> 3))
    run(0, 1, 8'hFF, 0, 0, 0, 0);
    `CHK(DUT.o_status, 8'(st))
    run(0, 0, 0, 0, 0, 0, 3);
    `CHK(DUT.o_status[4:3], 2'(st >> 3))
    $display("clear and reset cause done");
    @(negedge i_sys_clk);
    route = 1'b1;
    tick = 1'b1;
    #1 `CHK(DUT.o_timer_zero_tick, 1'b1)
    @(negedge i_sys_clk);
    route = 1'b0;
    #1 `CHK(DUT.o_timer_zero_tick, 1'b0)
    $display("timer routing done");
    @(negedge i_sys_clk);
    i_arst_n = 1'b0;
    #1 `CHK(DUT.o_status, 8'h18)
    @(negedge i_sys_clk);
    i_arst_n = 1'b1;
    st = 8'h18;
    run(0, 1, 8'h60, 0, 0, 0, 0);
    `CHK(DUT.o_bank.direct_bank, 2'h3)
    `CHK(DUT.o_status, 8'(st))
    $display("mid-run reset done");
    wrap_up();
  end

  initial begin
    #500000;
    bad_count++;
    wrap_up();
  end
endmodule : alu_status_bank_select_reg_tb_top

// File: verif/psr_core_model.sv
`timescale 1ns/10ps
module psr_core_model (
  input  wire logic        i_sys_clk,
  output psr_pkg::psr_wr_s o_wr,
  output psr_pkg::psr_op_e o_op,
  output logic [7:0]       o_a,
  output logic [7:0]       o_b,
  output logic [7:0]       o_lres,
  output logic [2:0]       o_evt
);
  initial begin
    o_wr   = '0;
    o_op   = psr_pkg::PSR_OP_NONE;
    o_a    = 8'h00;
    o_b    = 8'h00;
    o_lres = 8'h00;
    o_evt  = 3'h0;
  end
  // one instruction per cycle, then idle with scrambled data lines
  task automatic exec(input psr_pkg::psr_op_e op, input logic hit,
                      input logic [7:0] wd, a, b, lr, input logic [2:0] ev);
    @(negedge i_sys_clk);
    o_wr   = '{wr_en: hit, addr: hit ? 9'h083 : 9'h020, wdata: wd};
    o_op   = op;
    o_a    = a;
    o_b    = b;
    o_lres = lr;
    o_evt  = ev;
    @(negedge i_sys_clk);
    o_wr   = '{wr_en: 1'b0, addr: ~o_wr.addr, wdata: ~wd};
    o_op   = psr_pkg::PSR_OP_NONE;
    o_a    = ~a;
    o_b    = ~b;
    o_evt  = 3'h0;
  endtask : exec
endmodule : psr_core_model
